// ==== rtl/bss_pkg.sv ====
// Package: shared types and constants of the bus sideband block
// Assumes one bus clock, synchronous active-high reset.
// Summary of operation
// - Parity high for even count of lows
// - Undriven status 000 reads parity high, correct
// - Presence indicator output held permanently low
// - Management interrupt request accepted only from the run state
// - On interrupt, save state, enter management state
// - Issue acknowledge transaction, then run handler
// - Request active at reset release tristates outputs
// - Clock-stop request acknowledges, then enters stopped state
// - Gate core clocks except bus and interrupt units
// - Keep snooping and servicing interrupts while stopped
// - Release restarts all clocks, resumes execution
// - Bus clock unaffected; request is asynchronous
// - Sample configuration lines at reset release
package bss_pkg;

  // ==========================================================
  // Widths and constants
  localparam int          BSS_RS_W       = 3;
  localparam int          BSS_CFG_W      = 8;
  localparam int          BSS_SYNC_W     = 2;
  localparam logic [2:0]  BSS_RS_IDLE    = 3'h0;
  localparam logic [7:0]  BSS_CFG_RST    = 8'h00;
  localparam int          BSS_SAVE_CYC   = 2;

  // ==========================================================
  // Bus transaction kinds issued by the block
  typedef enum logic [1:0] {
    BSS_ACK_NONE  = 2'h0,
    BSS_ACK_SMI   = 2'h1,
    BSS_ACK_STOP  = 2'h2
  } bss_ack_e;

  // Control states, Gray along the usual path
  typedef enum logic [2:0] {
    BSS_RUN       = 3'b000,
    BSS_SAVE      = 3'b001,
    BSS_SMI_ACK   = 3'b011,
    BSS_SMI_RUN   = 3'b010,
    BSS_STOP_ACK  = 3'b110,
    BSS_STOPPED   = 3'b111
  } bss_state_e;

  typedef struct packed {
    logic [2:0] response_status_n;
    logic       response_parity_n;
    logic       response_valid;
  } bss_resp_s;

  typedef struct packed {
    logic       req;
    bss_ack_e   kind;
  } bss_ack_s;

endpackage : bss_pkg

// ==== rtl/bss_sync.sv ====
// Two-flop synchroniser bank for asynchronous request levels.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/10ps
module bss_sync
  import bss_pkg::*;
#(
  parameter int W   = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  if (W < 1) begin : g_bad_width
    $error("bss_sync: width must be at least 1");
  end

  // ==========================================================
  // Stages
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : bss_sync

// ==== rtl/bss_sideband.sv ====
// Sideband control: response parity check, presence indicator,
// management interrupt entry and clock-stop handling.
// Assumes clk_sys is the bus clock; requests arrive asynchronously.
`timescale 1ns/10ps
module bss_sideband
  import bss_pkg::*;
#(
  parameter int SAVE_CYC = BSS_SAVE_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire bss_resp_s            resp_in,
  input  wire logic                 sys_mgmt_interrupt_req_n,
  input  wire logic                 clock_stop_request_n,
  input  wire logic [BSS_CFG_W-1:0] config_lines,
  input  wire logic                 ack_done,
  input  wire logic                 save_done,
  input  wire logic                 rsm_exit,
  output logic                      presence_indicator_n,
  output logic                      parity_error,
  output bss_ack_s                  ack_out,
  output logic                      save_state_req,
  output logic                      sys_mgmt_state,
  output logic                      handler_start,
  output logic                      core_clk_en,
  output logic                      bus_unit_clk_en,
  output logic                      local_interrupt_unit_clk_en,
  output logic                      snoop_en,
  output logic                      outputs_tristate,
  output logic [BSS_CFG_W-1:0]      config_q
);

  if (SAVE_CYC < 1) begin : g_bad_save_cyc
    $error("bss_sideband: SAVE_CYC must be at least 1");
  end

  // ==========================================================
  // Request synchronisers
  logic [1:0] req_sync;
  logic       smi_act;
  logic       stop_act;

  bss_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({sys_mgmt_interrupt_req_n, clock_stop_request_n}),
    .sync_out (req_sync)
  );

  assign smi_act  = ~req_sync[1];
  assign stop_act = ~req_sync[0];

  // ==========================================================
  // Presence indicator
  assign presence_indicator_n = 1'b0;

  // ==========================================================
  // Response parity check
  logic parity_error_q;
  logic parity_error_d;
  logic exp_par;

  always_comb begin
    // Even count of low status lines gives a high parity line
    exp_par = ~(^(~resp_in.response_status_n));
    parity_error_d = 1'b0;
    if (resp_in.response_valid &&
        resp_in.response_status_n != ~BSS_RS_IDLE) begin
      parity_error_d = (resp_in.response_parity_n != exp_par);
    end else if (resp_in.response_status_n == ~BSS_RS_IDLE) begin
      // Undriven status: pulled-high parity counts as correct
      parity_error_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) parity_error_q <= 1'b0;
    else     parity_error_q <= parity_error_d;
  end

  assign parity_error = parity_error_q;

  // ==========================================================
  // Reset release: configuration capture and tristate strap
  logic                 rst_prev_q;
  logic                 rst_prev_d;
  logic [BSS_CFG_W-1:0] cfg_q;
  logic [BSS_CFG_W-1:0] cfg_d;
  logic                 tri_q;
  logic                 tri_d;
  logic                 rel_edge;

  always_comb begin
    rel_edge   = rst_prev_q;
    rst_prev_d = 1'b0;
    cfg_d      = cfg_q;
    tri_d      = tri_q;
    if (rel_edge) begin
      cfg_d = config_lines;
      tri_d = ~sys_mgmt_interrupt_req_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_prev_q <= 1'b1;
      cfg_q      <= BSS_CFG_RST;
      tri_q      <= 1'b0;
    end else begin
      rst_prev_q <= rst_prev_d;
      cfg_q      <= cfg_d;
      tri_q      <= tri_d;
    end
  end

  assign config_q         = cfg_q;
  assign outputs_tristate = tri_q;

  // ==========================================================
  // Control state machine
  bss_state_e state_q;
  bss_state_e state_d;
  logic [7:0] save_cnt_q;
  logic [7:0] save_cnt_d;
  logic       start_q;
  logic       start_d;

  always_comb begin
    state_d    = state_q;
    save_cnt_d = save_cnt_q;
    start_d    = 1'b0;
    unique case (state_q)
      BSS_RUN: begin
        if (smi_act) begin
          state_d    = BSS_SAVE;
          save_cnt_d = 8'h00;
        end else if (stop_act) begin
          state_d = BSS_STOP_ACK;
        end
      end
      BSS_SAVE: begin
        // State save runs at least SAVE_CYC cycles, until core done
        if (save_cnt_q != 8'hff) save_cnt_d = save_cnt_q + 8'h01;
        if (save_done && save_cnt_q >= 8'(SAVE_CYC - 1)) begin
          state_d = BSS_SMI_ACK;
        end
      end
      BSS_SMI_ACK: begin
        if (ack_done) begin
          state_d = BSS_SMI_RUN;
          start_d = 1'b1;
        end
      end
      BSS_SMI_RUN: begin
        if (rsm_exit) state_d = BSS_RUN;
        else if (stop_act) state_d = BSS_STOP_ACK;
      end
      BSS_STOP_ACK: begin
        if (ack_done) state_d = BSS_STOPPED;
      end
      BSS_STOPPED: begin
        if (!stop_act) begin
          state_d = sys_mgmt_state ? BSS_SMI_RUN : BSS_RUN;
        end
      end
      default: state_d = BSS_RUN;
    endcase
  end

  // Management mode flag survives a stop/restart excursion
  logic smm_q;
  logic smm_d;

  always_comb begin
    smm_d = smm_q;
    if (state_q == BSS_SAVE && state_d == BSS_SMI_ACK) smm_d = 1'b1;
    else if (state_q == BSS_SMI_RUN && rsm_exit)       smm_d = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= BSS_RUN;
      save_cnt_q <= 8'h00;
      start_q    <= 1'b0;
      smm_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      save_cnt_q <= save_cnt_d;
      start_q    <= start_d;
      smm_q      <= smm_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    ack_out.req  = 1'b0;
    ack_out.kind = BSS_ACK_NONE;
    if (state_q == BSS_SMI_ACK) begin
      ack_out.req  = 1'b1;
      ack_out.kind = BSS_ACK_SMI;
    end else if (state_q == BSS_STOP_ACK) begin
      ack_out.req  = 1'b1;
      ack_out.kind = BSS_ACK_STOP;
    end
  end

  assign save_state_req              = (state_q == BSS_SAVE);
  assign sys_mgmt_state              = smm_q;
  assign handler_start               = start_q;
  assign core_clk_en                 = (state_q != BSS_STOPPED);
  assign bus_unit_clk_en             = 1'b1;
  assign local_interrupt_unit_clk_en = 1'b1;
  assign snoop_en                    = 1'b1;

endmodule : bss_sideband

// ==== dv/bss_sideband_assertions.sv ====
// Checker: port timing relations of the sideband block.
// Assumes binding into bss_sideband; one clock domain.
`timescale 1ns/10ps
module bss_sideband_assertions
  import bss_pkg::*;
#(
  parameter int SAVE_CYC = BSS_SAVE_CYC
) (
  input wire logic                 clk_sys,
  input wire logic                 rst,
  input wire bss_resp_s            resp_in,
  input wire logic                 sys_mgmt_interrupt_req_n,
  input wire logic                 clock_stop_request_n,
  input wire logic [BSS_CFG_W-1:0] config_lines,
  input wire logic                 ack_done,
  input wire logic                 presence_indicator_n,
  input wire logic                 parity_error,
  input wire bss_ack_s             ack_out,
  input wire logic                 save_state_req,
  input wire logic                 sys_mgmt_state,
  input wire logic                 handler_start,
  input wire logic                 core_clk_en,
  input wire logic                 bus_unit_clk_en,
  input wire logic                 local_interrupt_unit_clk_en,
  input wire logic                 snoop_en,
  input wire logic                 outputs_tristate,
  input wire logic [BSS_CFG_W-1:0] config_q
);
  // ==========================================================
  // Properties
  logic [7:0] sv_cnt;
  logic       par_ok;
  always_ff @(posedge clk_sys) sv_cnt <= (rst || !save_state_req) ? 8'h00 : sv_cnt + 8'h01;
  assign par_ok = resp_in.response_parity_n == ^resp_in.response_status_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_PRESENCE: assert property (presence_indicator_n == 1'b0)
    else $error("presence not low");
  AST_UNITS: assert property (bus_unit_clk_en && local_interrupt_unit_clk_en && snoop_en)
    else $error("bus side gated");
  AST_PAR_BAD: assert property (resp_in.response_valid && !par_ok
    && resp_in.response_status_n != 3'h7 |=> parity_error) else $error("parity missed");
  AST_PAR_GOOD: assert property (!resp_in.response_valid || par_ok
    || resp_in.response_status_n == 3'h7 |=> !parity_error) else $error("false parity");
  AST_SAVE_MIN: assert property ($fell(save_state_req) |-> sv_cnt >= SAVE_CYC)
    else $error("save too short");
  AST_ACK_HOLD: assert property (ack_out.req && !ack_done |=> ack_out.req
    && $stable(ack_out.kind)) else $error("ack dropped");
  AST_HANDLER: assert property (handler_start |-> sys_mgmt_state && $past(ack_done)
    && $past(ack_out.kind) == BSS_ACK_SMI) else $error("handler entry");
  AST_SMM_ACK: assert property ($rose(sys_mgmt_state) |-> ack_out.req
    && ack_out.kind == BSS_ACK_SMI) else $error("mgmt ack missing");
  AST_STOP_GATE: assert property (ack_out.req && ack_out.kind == BSS_ACK_STOP
    && ack_done |=> !core_clk_en) else $error("core not gated");
  AST_RESTART: assert property (!core_clk_en && clock_stop_request_n
    |-> ##[1:4] core_clk_en) else $error("no restart");
  AST_CFG: assert property ($past(rst) && !rst |=> config_q == $past(config_lines)
    && outputs_tristate == !$past(sys_mgmt_interrupt_req_n)) else $error("capture");
endmodule : bss_sideband_assertions

bind bss_sideband bss_sideband_assertions #(.SAVE_CYC(SAVE_CYC)) bss_chk (.clk_sys, .rst,
  .resp_in, .sys_mgmt_interrupt_req_n, .clock_stop_request_n, .config_lines, .ack_done,
  .presence_indicator_n, .parity_error, .ack_out, .save_state_req, .sys_mgmt_state,
  .handler_start, .core_clk_en, .bus_unit_clk_en, .local_interrupt_unit_clk_en, .snoop_en,
  .outputs_tristate, .config_q);

// ==== dv/bss_partner.sv ====
// Partner: response agent and bus/core completion model.
// Assumes dly sets how many cycles each completion waits.
`timescale 1ns/10ps
module bss_partner
  import bss_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       drive,
  input  wire logic [2:0] status_n,
  input  wire logic       corrupt,
  input  wire logic [3:0] dly,
  input  wire bss_ack_s   ack_out,
  input  wire logic       save_state_req,
  output bss_resp_s       resp,
  output logic            ack_done,
  output logic            save_done
);
  // ==========================================================
  // Response lines float high when undriven
  logic [3:0] cnt = 4'h0;
  assign resp.response_valid    = drive;
  assign resp.response_status_n = drive ? status_n : 3'h7;
  assign resp.response_parity_n = drive ? (^status_n ^ corrupt) : 1'b1;
  assign ack_done  = ack_out.req && cnt >= dly;
  assign save_done = save_state_req && cnt >= dly;
  always_ff @(posedge clk_sys) begin
    cnt <= ((ack_out.req && !ack_done) || (save_state_req && !save_done)) ? cnt + 4'h1 : 4'h0;
  end
endmodule : bss_partner

// ==== dv/bss_sideband_tb.sv ====
// Testbench: reset capture, parity checking, mode entry and exit.
// Assumes the partner model answers the block's handshakes.
`timescale 1ns/10ps
module bss_sideband_tb
  import bss_pkg::*;
;
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 sys_mgmt_interrupt_req_n = 1'b1;
  logic                 clock_stop_request_n = 1'b1;
  logic [BSS_CFG_W-1:0] config_lines = 8'h00, config_q;
  logic                 rsm_exit = 1'b0, drive = 1'b0, corrupt = 1'b0;
  logic [2:0]           status_n = 3'h7;
  logic [3:0]           dly = 4'h0;
  bss_resp_s            resp_in;
  bss_ack_s             ack_out;
  logic                 ack_done, save_done, presence_indicator_n, parity_error;
  logic                 save_state_req, sys_mgmt_state, handler_start, core_clk_en;
  logic                 bus_unit_clk_en, local_interrupt_unit_clk_en, snoop_en;
  logic                 outputs_tristate;
  int                   failures = 0, cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  bss_sideband bss_sideband_inst (.clk_sys, .rst, .resp_in, .sys_mgmt_interrupt_req_n,
    .clock_stop_request_n, .config_lines, .ack_done, .save_done, .rsm_exit,
    .presence_indicator_n, .parity_error, .ack_out, .save_state_req, .sys_mgmt_state,
    .handler_start, .core_clk_en, .bus_unit_clk_en, .local_interrupt_unit_clk_en,
    .snoop_en, .outputs_tristate, .config_q);
  bss_partner bss_partner_inst (.clk_sys, .drive, .status_n, .corrupt, .dly, .ack_out,
    .save_state_req, .resp(resp_in), .ack_done, .save_done);
  // ==========================================================
  // Shared tasks
  task automatic fail(input string m);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // Mode 0 waits for handler start, 2 and 3 for core clock low and high
  task automatic wait_on(input int w);
    int n;
    n = 0;
    while (!((w == 0) ? handler_start === 1'b1 : core_clk_en === w[0]) && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 50) begin
      fail("wait timed out");
      wrap_up();
    end
  endtask : wait_on
  // ==========================================================
  // Scenarios
  task automatic t_reset(input logic smi, input logic [7:0] cfg);
    @(negedge clk_sys);
    rst = 1'b1;
    sys_mgmt_interrupt_req_n = smi;
    config_lines = cfg;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk(config_q, cfg, "config capture");
    chk(outputs_tristate, !smi, "tristate");
    chk(presence_indicator_n, 8'h00, "presence");
    sys_mgmt_interrupt_req_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    $display("reset test done");
  endtask : t_reset
  task automatic t_parity();
    for (int i = 0; i < 24; i++) begin
      drive = i < 16;
      status_n = i[2:0];
      corrupt = i[3];
      @(negedge clk_sys);
      chk(parity_error, i[3] && i < 16 && i[2:0] != 3'h7, "parity flag");
    end
    drive = 1'b0;
    $display("parity test done");
  endtask : t_parity
  task automatic t_modes(input logic [3:0] d);
    dly = d;
    sys_mgmt_interrupt_req_n = 1'b0;
    clock_stop_request_n = 1'b0;
    wait_on(0);
    chk(sys_mgmt_state, 8'h01, "mgmt entered");
    sys_mgmt_interrupt_req_n = 1'b1;
    wait_on(2);
    chk({bus_unit_clk_en, local_interrupt_unit_clk_en, snoop_en}, 8'h07, "units");
    clock_stop_request_n = 1'b1;
    wait_on(3);
    chk(sys_mgmt_state, 8'h01, "mgmt kept");
    rsm_exit = 1'b1;
    @(negedge clk_sys);
    rsm_exit = 1'b0;
    @(negedge clk_sys);
    chk(sys_mgmt_state, 8'h00, "mgmt left");
    clock_stop_request_n = 1'b0;
    wait_on(2);
    clock_stop_request_n = 1'b1;
    wait_on(3);
    chk(sys_mgmt_state, 8'h00, "run resumed");
    $display("mode test done");
  endtask : t_modes
  initial begin
    t_reset(1'b0, 8'ha5);
    t_reset(1'b1, 8'h5a);
    t_parity();
    t_modes(4'h3);
    t_modes(4'h0);
    wrap_up();
  end
endmodule : bss_sideband_tb
